// [hw/clis_cell.sv]
// Configurable logic cell: input selection, gating, function and polarity.
//
// How it works
// [R1] Thirty-two candidates: synced pins, sibling outputs and internal sources.
// [R2] Four data lines feed gates that drive one selected single-output function.
// [R3] Four independent selectors, each routing any candidate to its own line.
// [R4] Each selector has its own five-bit code, one per line.
// [R5] The code value is the index of the candidate taken, zero to 31.
// [R6] Codes zero to three take the four pin inputs.
// [R7] Codes four to seven take cell outputs one to four.
// [R8] Higher codes take internal sources; code 19 is the zero-cross output.
// [R9] Codes are undefined until written; software writes all before enabling.
// [R10] Codes may be rewritten at any time while running, without reset.
// [R11] Path order: selection, gating, logic function, output polarity.
// [R12] Final output goes to peripherals and to the pin mapping.
// [R13] Gates AND any true or inverted lines, output optionally inverted.
// [R14] Reset clears the control register only; selection and gating stay.
// [R15] A code change reaches its data line combinationally, no register.
`timescale 1ns/1ps
module clis_cell
	import clis_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Register port
	input wire clis_bus_req_s bus_req,
	output logic [DATA_W-1:0] bus_rdata,
	// Sources
	input wire logic [PIN_COUNT-1:0] cell_pin_input,
	input wire logic [SIBLING_COUNT-1:0] cell_outputs,
	input wire logic [INTERNAL_COUNT-1:0] internal_sources,
	// Results
	output logic [LINE_COUNT-1:0] data_line,
	output logic cell_output,
	output logic pin_output
);

	// ****************************************************************
	// Configuration state
	// ****************************************************************
	logic [CODE_W-1:0] line_source_code [LINE_COUNT];
	logic [2*LINE_COUNT-1:0] gate_select [LINE_COUNT];
	logic [LINE_COUNT-1:0] gate_polarity;
	logic output_polarity;
	logic cell_enable;
	logic [CTRL_MODE_W-1:0] mode_bits;
	logic [PIN_COUNT-1:0] pin_meta;
	logic [PIN_COUNT-1:0] pin_sync;
	logic [CANDIDATE_COUNT-1:0] candidate_input;
	logic [LINE_COUNT-1:0] gate_out;
	logic func_state;
	logic next_func_state;
	logic gate1_prev;
	logic gate1_rise;
	logic func_value;
	clis_mode_e mode;
	logic sel0_known;
	logic gate0_known;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base,
		input int idx);
		hit = (a == ADDR_W'(base + ADDR_W'(idx)));
	endfunction

	// ****************************************************************
	// Control register
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (rst) begin
			cell_enable <= CONTROL_RESET[CTRL_ENABLE_BIT]; // [R14]
			mode_bits <= CONTROL_RESET[CTRL_MODE_LSB +: CTRL_MODE_W]; // [R14]
		end else if (bus_req.write && bus_req.addr == ADDR_CONTROL) begin
			cell_enable <= bus_req.wdata[CTRL_ENABLE_BIT];
			mode_bits <= bus_req.wdata[CTRL_MODE_LSB +: CTRL_MODE_W];
		end
	end

	assign mode = clis_mode_e'(mode_bits);

	// ****************************************************************
	// Selection and gating settings
	// ****************************************************************
	// These carry no reset: a reset keeps what software last wrote, and
	// before the first write they are undefined.
	always_ff @(posedge clock) begin
		for (int i = 0; i < LINE_COUNT; i++) begin
			if (bus_req.write && hit(bus_req.addr, ADDR_SELECT_FIRST, i)) begin
				line_source_code[i] <= bus_req.wdata[CODE_W-1:0]; // [R4] [R9] [R10] [R14]
			end
		end
	end

	always_ff @(posedge clock) begin
		for (int i = 0; i < LINE_COUNT; i++) begin
			if (bus_req.write && hit(bus_req.addr, ADDR_GATE_FIRST, i)) begin
				gate_select[i] <= bus_req.wdata; // [R13] [R14]
			end
		end
	end

	always_ff @(posedge clock) begin
		if (bus_req.write && bus_req.addr == ADDR_POLARITY) begin
			gate_polarity <= bus_req.wdata[LINE_COUNT-1:0];
			output_polarity <= bus_req.wdata[POL_OUTPUT_BIT];
		end
	end

	// ****************************************************************
	// Read port
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (rst) begin
			bus_rdata <= READ_IDLE;
		end else if (bus_req.read) begin
			bus_rdata <= READ_IDLE;
			if (bus_req.addr == ADDR_CONTROL) begin
				bus_rdata[CTRL_ENABLE_BIT] <= cell_enable;
				bus_rdata[CTRL_OUT_BIT] <= cell_output;
				bus_rdata[CTRL_MODE_LSB +: CTRL_MODE_W] <= mode_bits;
			end
			if (bus_req.addr == ADDR_POLARITY) begin
				bus_rdata[LINE_COUNT-1:0] <= gate_polarity;
				bus_rdata[POL_OUTPUT_BIT] <= output_polarity;
			end
			if (bus_req.addr == ADDR_OUTPUT) begin
				bus_rdata[0] <= cell_output;
			end
			for (int i = 0; i < LINE_COUNT; i++) begin
				if (hit(bus_req.addr, ADDR_SELECT_FIRST, i)) begin
					bus_rdata[CODE_W-1:0] <= line_source_code[i];
				end
				if (hit(bus_req.addr, ADDR_GATE_FIRST, i)) begin
					bus_rdata <= gate_select[i];
				end
			end
		end else begin
			bus_rdata <= READ_IDLE;
		end
	end

	// ****************************************************************
	// Candidate pool
	// ****************************************************************
	// Pins come from outside the clock domain and are synchronised first.
	always_ff @(posedge clock) begin
		if (rst) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= cell_pin_input;
			pin_sync <= pin_meta;
		end
	end

	assign candidate_input = {internal_sources, cell_outputs, pin_sync}; // [R1] [R6] [R7] [R8]

	// ****************************************************************
	// Selection and gating stages
	// ****************************************************************
	for (genvar i = 0; i < LINE_COUNT; i++) begin : g_line
		clis_source_mux #(
			.COUNT(CANDIDATE_COUNT)
		) u_mux (
			.candidate_input(candidate_input),
			.line_source_code(line_source_code[i]),
			.data_line(data_line[i])
		); // [R3] [R5] [R15]

		clis_data_gate u_gate (
			.data_line(data_line),
			.gate_select(gate_select[i]),
			.gate_polarity(gate_polarity[i]),
			.gate_out(gate_out[i])
		); // [R2] [R11] [R13]
	end

	// ****************************************************************
	// Logic function stage
	// ****************************************************************
	// Sequential modes are sampled on the system clock; gate 1 acts as the
	// function clock through an edge detect, so pulses shorter than one
	// system period are lost. The trade buys a fully synchronous cell.
	always_ff @(posedge clock) begin
		if (rst) begin
			gate1_prev <= 1'b0;
		end else begin
			gate1_prev <= gate_out[0];
		end
	end

	assign gate1_rise = gate_out[0] & ~gate1_prev;

	always_comb begin
		next_func_state = func_state;
		func_value = func_state;
		case (mode)
			MODE_AND_OR: func_value = (gate_out[0] & gate_out[1]) | (gate_out[2] & gate_out[3]);
			MODE_OR_XOR: func_value = (gate_out[0] | gate_out[1]) ^ (gate_out[2] | gate_out[3]);
			MODE_AND4: func_value = &gate_out;
			MODE_SR_LATCH: begin
				if (gate_out[2] | gate_out[3]) begin
					next_func_state = 1'b0;
				end else if (gate_out[0] | gate_out[1]) begin
					next_func_state = 1'b1;
				end
				func_value = next_func_state;
			end
			MODE_DFF_SR: begin
				if (gate_out[3]) begin
					next_func_state = 1'b1;
				end else if (gate_out[2]) begin
					next_func_state = 1'b0;
				end else if (gate1_rise) begin
					next_func_state = gate_out[1];
				end
				func_value = next_func_state;
			end
			MODE_DFF_R: begin
				if (gate_out[2] | gate_out[3]) begin
					next_func_state = 1'b0;
				end else if (gate1_rise) begin
					next_func_state = gate_out[1];
				end
				func_value = next_func_state;
			end
			MODE_JK_R: begin
				if (gate_out[2]) begin
					next_func_state = 1'b0;
				end else if (gate1_rise) begin
					case ({gate_out[1], gate_out[3]})
						2'b10: next_func_state = 1'b1;
						2'b01: next_func_state = 1'b0;
						2'b11: next_func_state = ~func_state;
						default: next_func_state = func_state;
					endcase
				end
				func_value = next_func_state;
			end
			MODE_LATCH_SR: begin
				if (gate_out[3]) begin
					next_func_state = 1'b1;
				end else if (gate_out[0]) begin
					next_func_state = 1'b0;
				end else if (gate_out[2]) begin
					next_func_state = gate_out[1];
				end
				func_value = next_func_state;
			end
			default: func_value = 1'b0;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst || !cell_enable) begin
			func_state <= 1'b0;
		end else begin
			func_state <= next_func_state;
		end
	end

	// ****************************************************************
	// Output polarity and distribution
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (rst || !cell_enable) begin
			cell_output <= 1'b0;
		end else begin
			cell_output <= func_value ^ output_polarity; // [R11]
		end
	end

	assign pin_output = cell_output; // [R12]

	// ****************************************************************
	// Checks
	// ****************************************************************
	// Check helpers only: they rise on the first write to line 1's code and gate 1.
	// Until then both settings are undefined, so there is nothing to keep across reset.
	always_ff @(posedge clock) begin
		if (bus_req.write && bus_req.addr == ADDR_SELECT_FIRST) begin
			sel0_known <= 1'b1;
		end
		if (bus_req.write && bus_req.addr == ADDR_GATE_FIRST) begin
			gate0_known <= 1'b1;
		end
	end

	sequence s_read_select0;
		bus_req.read && bus_req.addr == ADDR_SELECT_FIRST;
	endsequence

	sequence s_enabled_and4;
		cell_enable && mode == MODE_AND4 && !bus_req.write;
	endsequence

	a_line_follows_code: assert property (@(posedge clock) disable iff (rst)
		line_source_code[1] == LAST_CODE
		|-> data_line[1] == internal_sources[INTERNAL_COUNT-1]) // [R3] [R5] [R15]
		else $error("data line 2 does not follow its code");
	a_pin_code_map: assert property (@(posedge clock) disable iff (rst)
		line_source_code[0] == PIN_CODE_FIRST |-> data_line[0] == pin_sync[0]) // [R6]
		else $error("code zero does not route pin zero");
	a_sibling_code_map: assert property (@(posedge clock) disable iff (rst)
		line_source_code[2] == SIBLING_CODE_FIRST + 5'h03 |-> data_line[2] == cell_outputs[3]) // [R7]
		else $error("code seven does not route cell four");
	a_zero_cross_map: assert property (@(posedge clock) disable iff (rst)
		line_source_code[3] == ZERO_CROSS_CODE
		|-> data_line[3] == internal_sources[ZERO_CROSS_CODE - INTERNAL_CODE_FIRST]) // [R8]
		else $error("zero-cross code routes the wrong source");
	a_control_reset: assert property (@(posedge clock)
		rst |=> !cell_enable && mode_bits == 3'h0 && !cell_output) // [R14]
		else $error("control not cleared by reset");
	a_select_kept_reset: assert property (@(posedge clock)
		rst && !bus_req.write && sel0_known && gate0_known
		|=> $stable(line_source_code[0]) && $stable(gate_select[0])) // [R14]
		else $error("selection changed across reset");
	a_select_write: assert property (@(posedge clock) disable iff (rst)
		bus_req.write && bus_req.addr == ADDR_SELECT_FIRST + 4'h1
		|=> line_source_code[1] == $past(bus_req.wdata[CODE_W-1:0])) // [R4] [R10]
		else $error("select code write not taken");
	a_select_readback: assert property (@(posedge clock) disable iff (rst)
		s_read_select0 |=> bus_rdata == {3'h0, $past(line_source_code[0])}) // [R4]
		else $error("select code read back wrong");
	a_disabled_quiet: assert property (@(posedge clock) disable iff (rst)
		!cell_enable [*2] |-> !cell_output && !pin_output) // [R12]
		else $error("output active while disabled");
	a_empty_gate: assert property (@(posedge clock) disable iff (rst)
		gate_select[0] == 8'h00 |-> gate_out[0] == gate_polarity[0]) // [R13]
		else $error("empty gate ignores polarity");
	a_and4_output: assert property (@(posedge clock) disable iff (rst)
		s_enabled_and4 ##1 s_enabled_and4
		|-> cell_output == ($past(&gate_out) ^ $past(output_polarity))) // [R2] [R11]
		else $error("four-input AND output wrong");

endmodule

// [hw/clis_data_gate.sv]
// One data gate: true or inverted lines ANDed, with output polarity.
`timescale 1ns/1ps
module clis_data_gate
	import clis_pkg::*;
(
	// Lines and setting
	input wire logic [LINE_COUNT-1:0] data_line,
	input wire logic [2*LINE_COUNT-1:0] gate_select,
	input wire logic gate_polarity,
	// Gate result
	output logic gate_out
);

	logic [2*LINE_COUNT-1:0] terms;

	// Even bits take a line as is, odd bits take it inverted.
	always_comb begin
		for (int i = 0; i < LINE_COUNT; i++) begin
			terms[2*i] = ~gate_select[2*i] | data_line[i];
			terms[2*i+1] = ~gate_select[2*i+1] | ~data_line[i];
		end
	end

	// Polarity one passes the AND, zero inverts it.
	assign gate_out = gate_polarity ? (&terms) : ~(&terms);

endmodule

// [hw/clis_pkg.sv]
// Shared constants, types and register map of the logic cell input stage.
package clis_pkg;

	// ****************************************************************
	// Structure of the cell
	// ****************************************************************
	localparam int LINE_COUNT = 4;
	localparam int CANDIDATE_COUNT = 32;
	localparam int CODE_W = 5;
	localparam int PIN_COUNT = 4;
	localparam int SIBLING_COUNT = 4;
	localparam int INTERNAL_COUNT = 24;
	localparam int SYNC_STAGES = 2;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 4;

	// ****************************************************************
	// Candidate codes
	// ****************************************************************
	localparam logic [CODE_W-1:0] PIN_CODE_FIRST = 5'h00;
	localparam logic [CODE_W-1:0] SIBLING_CODE_FIRST = 5'h04;
	localparam logic [CODE_W-1:0] INTERNAL_CODE_FIRST = 5'h08;
	localparam logic [CODE_W-1:0] ZERO_CROSS_CODE = 5'h13;
	localparam logic [CODE_W-1:0] LAST_CODE = 5'h1F;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_POLARITY = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_SELECT_FIRST = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_GATE_FIRST = 4'h6;
	localparam logic [ADDR_W-1:0] ADDR_OUTPUT = 4'hA;

	// ****************************************************************
	// Field positions and values after reset
	// ****************************************************************
	localparam int CTRL_ENABLE_BIT = 7;
	localparam int CTRL_OUT_BIT = 5;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_MODE_W = 3;
	localparam int POL_OUTPUT_BIT = 7;
	localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h00;
	localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

	typedef enum logic [CTRL_MODE_W-1:0] {
		MODE_AND_OR,
		MODE_OR_XOR,
		MODE_AND4,
		MODE_SR_LATCH,
		MODE_DFF_SR,
		MODE_DFF_R,
		MODE_JK_R,
		MODE_LATCH_SR
	} clis_mode_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic write;
		logic read;
	} clis_bus_req_s;

endpackage

// [hw/clis_source_mux.sv]
// One 32-way source selector that drives a single data line.
`timescale 1ns/1ps
module clis_source_mux
	import clis_pkg::*;
#(
	parameter int COUNT = CANDIDATE_COUNT
) (
	// Candidates and code
	input wire logic [COUNT-1:0] candidate_input,
	input wire logic [CODE_W-1:0] line_source_code,
	// Selected line
	output logic data_line
);

	if (COUNT != (1 << CODE_W)) begin : g_check
		$error("clis_source_mux: candidate count must equal the code range");
	end

	// Purely combinational, so a new code reroutes the line at once.
	assign data_line = candidate_input[line_source_code];

endmodule

// [test/clis_far_side.sv]
// Behavioural model of the pins, peripherals and sibling cells around the cell.
`timescale 1ns/1ps
module clis_far_side
	import clis_pkg::*;
(
	// Requested candidate levels
	input wire logic [CANDIDATE_COUNT-1:0] want,
	// Sources seen by the cell
	output logic [PIN_COUNT-1:0] cell_pin_input,
	output logic [SIBLING_COUNT-1:0] cell_outputs,
	output logic [INTERNAL_COUNT-1:0] internal_sources
);
	// ****************************************************************
	// Source pool
	// ****************************************************************
	// Each candidate lands on exactly one source bit, so a wrong index shows at once.
	assign cell_pin_input = want[3:0];
	assign cell_outputs = want[7:4];
	assign internal_sources = want[31:8];
endmodule

// [test/configurable_logic_input_select_bench.sv]
// Self-checking bench for the logic cell input stage.
`timescale 1ns/1ps
module configurable_logic_input_select_bench
	import clis_pkg::*;
;
	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	localparam int CYCLE_LIMIT = 4000;
	logic clock;
	logic rst;
	clis_bus_req_s bus_req;
	logic [DATA_W-1:0] bus_rdata;
	logic [CANDIDATE_COUNT-1:0] want;
	logic [PIN_COUNT-1:0] cell_pin_input;
	logic [SIBLING_COUNT-1:0] cell_outputs;
	logic [INTERNAL_COUNT-1:0] internal_sources;
	logic [LINE_COUNT-1:0] data_line;
	logic cell_output;
	logic pin_output;
	int bad_count = 0;
	int n_compared = 0;
	int cycles = 0;

	clis_cell u_dut (
		.clock(clock),
		.rst(rst),
		.bus_req(bus_req),
		.bus_rdata(bus_rdata),
		.cell_pin_input(cell_pin_input),
		.cell_outputs(cell_outputs),
		.internal_sources(internal_sources),
		.data_line(data_line),
		.cell_output(cell_output),
		.pin_output(pin_output)
	);

	clis_far_side u_far (
		.want(want),
		.cell_pin_input(cell_pin_input),
		.cell_outputs(cell_outputs),
		.internal_sources(internal_sources)
	);

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic final_report();
		$display("Compared %0d values, %0d mismatches", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Every bus task starts and ends in the time step of a rising edge.
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge clock);
		bus_req <= '{a, d, 1'b0, 1'b0};
		@(posedge clock);
	endtask

	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clock);
		bus_req <= '{a, 8'h00, 1'b0, 1'b0};
		#1 check(bus_rdata, exp);
		@(posedge clock);
		#1 check(bus_rdata, READ_IDLE);
		@(posedge clock);
	endtask

	task automatic line_chk(input int k, input logic exp);
		check({7'h00, data_line[k]}, {7'h00, exp});
	endtask

	// The output is registered one edge behind the gates; two edges leave margin.
	task automatic out_chk(input logic exp);
		repeat (2) @(posedge clock);
		#1 check({7'h00, cell_output}, {7'h00, exp});
		check({7'h00, pin_output}, {7'h00, exp});
		@(posedge clock);
	endtask

	// ****************************************************************
	// Clock, timeout and tests
	// ****************************************************************
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == CYCLE_LIMIT) begin
			bad_count++;
			final_report();
		end
	end

	initial begin
		rst = 1'b1;
		bus_req = '0;
		want = '0;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		rd_chk(ADDR_CONTROL, CONTROL_RESET);
		rd_chk(4'hC, READ_IDLE);
		for (int k = 0; k < LINE_COUNT; k++) begin
			wr(ADDR_SELECT_FIRST + 4'(k), 8'h00);
		end
		// Walk every code on every line: the chosen candidate alone high, then alone low.
		for (int k = 0; k < LINE_COUNT; k++) begin
			for (int c = 0; c < CANDIDATE_COUNT; c++) begin
				wr(ADDR_SELECT_FIRST + 4'(k), 8'(c));
				want <= 32'h1 << c;
				repeat (3) @(posedge clock);
				#1 line_chk(k, 1'b1);
				@(posedge clock);
				want <= ~(32'h1 << c);
				repeat (3) @(posedge clock);
				#1 line_chk(k, 1'b0);
				@(posedge clock);
			end
			rd_chk(ADDR_SELECT_FIRST + 4'(k), {3'b000, LAST_CODE});
		end
		// Line 4 still holds code 31, whose source was low; the new level must show at once.
		want <= 32'h8000_0000;
		#1 line_chk(3, 1'b1);
		@(posedge clock);
		// Lines take internal sources 0 to 3; gate k passes line k true; AND of four gates.
		for (int k = 0; k < LINE_COUNT; k++) begin
			wr(ADDR_SELECT_FIRST + 4'(k), 8'(8 + k));
			wr(ADDR_GATE_FIRST + 4'(k), 8'h01 << (2 * k));
		end
		wr(ADDR_POLARITY, 8'h0F);
		wr(ADDR_CONTROL, 8'h82);
		want <= 32'h0000_0F00;
		out_chk(1'b1);
		rd_chk(ADDR_CONTROL, 8'hA2);
		rd_chk(ADDR_OUTPUT, 8'h01);
		wr(ADDR_SELECT_FIRST, 8'h0C);
		out_chk(1'b0);
		wr(ADDR_SELECT_FIRST, 8'h08);
		out_chk(1'b1);
		wr(ADDR_POLARITY, 8'h8F);
		out_chk(1'b0);
		wr(ADDR_POLARITY, 8'h0F);
		wr(ADDR_GATE_FIRST, 8'h00);
		want <= 32'h0000_0E00;
		out_chk(1'b1);
		wr(ADDR_POLARITY, 8'h0E);
		out_chk(1'b0);
		wr(ADDR_POLARITY, 8'h0F);
		wr(ADDR_GATE_FIRST + 4'h1, 8'h08);
		out_chk(1'b0);
		wr(ADDR_GATE_FIRST + 4'h1, 8'h04);
		out_chk(1'b1);
		// A reset clears the control register but keeps the routing and gating.
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		#1 check({7'h00, cell_output}, 8'h00);
		@(posedge clock);
		rd_chk(ADDR_CONTROL, CONTROL_RESET);
		rd_chk(ADDR_SELECT_FIRST, 8'h08);
		rd_chk(ADDR_GATE_FIRST + 4'h1, 8'h04);
		#1 line_chk(1, 1'b1);
		@(posedge clock);
		// All four gates high: AND-OR gives one, OR-XOR zero, SR latch held in reset.
		wr(ADDR_CONTROL, 8'h80);
		out_chk(1'b1);
		wr(ADDR_CONTROL, 8'h81);
		out_chk(1'b0);
		wr(ADDR_CONTROL, 8'h83);
		out_chk(1'b0);
		// Gates 3 and 4 low release the latch reset, so the set input wins.
		want <= 32'h0000_0200;
		out_chk(1'b1);
		final_report();
	end
endmodule
